// ### hdl/config_serial_port_slave.sv
/*
  serial configuration port slave: 16-bit instruction then byte-wise
  register reads and writes, 3-wire or 4-wire, msb or lsb first.
  assumes: sclk only toggles while cs_n is low; sclk <= 10 MHz; the
  testbench resolves the shared data line from the output enables.
*/
`timescale 1ns/1ps
module config_serial_port_slave
  import cfg_port_pkg::*;
(
  // system clock domain
  input wire logic sys_clk,
  input wire logic rst_n,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_out_line,
  output logic serial_out_oe,
  // system side status and configuration
  input wire logic [7:0] status_in,
  output logic [NUM_REGS*8-1:0] cfg_out,
  output logic low_bit_order_select
);

  // register window decode, shared by read and write paths
  function automatic logic in_window(input logic [14:0] a);
    in_window = (a < 15'(NUM_REGS));
  endfunction

  function automatic logic is_writable(input logic [14:0] a);
    if (!in_window(a))
      is_writable = 1'b0;
    else if (a == REG_STATUS || (a >= REG_CHIP_TYPE && a <= REG_GRADE_REV))
      is_writable = 1'b0;
    else
      is_writable = 1'b1;
  endfunction

  // ---------------- link (sclk) domain ----------------
  phase_t phase_q;
  logic [3:0] cnt_q;
  logic [15:0] instr_q;
  logic [7:0] byte_q;
  logic rw_q;
  logic [14:0] addr_q;
  logic [7:0] tx_q;
  logic [7:0] regs_q [NUM_REGS];
  wr_evt_t evt_q;
  logic wr_tog_q;
  logic out_q;
  logic drive_q;
  logic [7:0] stat_link;
  // status capture flop, declared here as the link-side sync reads it
  logic [7:0] stat_sys_q;

  // configuration fields seen by the shifter
  wire logic cfg_lsb = regs_q[0][CFG_LSB_FIRST_BIT];
  wire logic cfg_inc = regs_q[0][CFG_ADDR_INC_BIT];
  wire logic cfg_four_wire = regs_q[0][CFG_FOUR_WIRE_BIT];

  // next shift values for either bit order
  wire logic [15:0] instr_next = cfg_lsb ? {sdio_in, instr_q[15:1]}
                                         : {instr_q[14:0], sdio_in};
  wire logic [7:0] byte_next = cfg_lsb ? {sdio_in, byte_q[7:1]}
                                       : {byte_q[6:0], sdio_in};
  wire logic instr_done = (phase_q == PH_INSTR) && (cnt_q == INSTR_LAST_CNT);
  wire logic byte_done = (phase_q == PH_DATA) && (cnt_q == BYTE_LAST_CNT);

  // address stepping between bytes
  wire logic [14:0] step_addr = cfg_inc ? 15'(addr_q + 15'h0001)
                                        : 15'(addr_q - 15'h0001);
  wire logic [14:0] start_addr = instr_next[ADDR_W-1:0];
  wire logic [14:0] rd_addr = instr_done ? start_addr : step_addr;
  wire logic wr_hit = byte_done && !rw_q && is_writable(addr_q);
  wire logic soft_rst = wr_hit && (addr_q == REG_CONFIG) && byte_next[CFG_SOFT_RESET_BIT];

  // read mux over the register window
  logic [7:0] rd_data;
  always_comb
  begin
    if (!in_window(rd_addr))
      rd_data = UNMAPPED_READ;
    else if (rd_addr == REG_STATUS)
      rd_data = stat_link;
    else if (rd_addr == REG_CHIP_TYPE)
      rd_data = CHIP_TYPE_CODE;
    else if (rd_addr == REG_PROD_ID_LO)
      rd_data = PROD_ID_LO_CODE;
    else if (rd_addr == REG_PROD_ID_HI)
      rd_data = PROD_ID_HI_CODE;
    else if (rd_addr == REG_GRADE_REV)
      rd_data = GRADE_REV_CODE;
    else
      rd_data = regs_q[rd_addr[3:0]];
  end

  // status crosses into the link domain as slow levels
  level_sync #(.WIDTH(8)) u_stat_sync (
    .clk(sclk),
    .rst_n(rst_n),
    .async_in(stat_sys_q),
    .sync_out(stat_link)
  );

  // sequencing, restarted by chip select high
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n || cs_n)
    begin
      phase_q <= PH_INSTR;
      cnt_q <= 4'h0;
      instr_q <= 16'h0000;
      byte_q <= 8'h00;
      rw_q <= 1'b0;
      addr_q <= 15'h0000;
      tx_q <= 8'h00;
    end
    else if (phase_q == PH_INSTR)
    begin
      instr_q <= instr_next;
      cnt_q <= 4'(cnt_q + 4'h1);
      if (instr_done)
      begin
        phase_q <= PH_DATA;
        cnt_q <= 4'h0;
        rw_q <= instr_next[INSTR_RW_BIT];
        addr_q <= start_addr;
        tx_q <= rd_data;
      end
    end
    else
    begin
      byte_q <= byte_next;
      cnt_q <= byte_done ? 4'h0 : 4'(cnt_q + 4'h1);
      if (byte_done)
      begin
        addr_q <= step_addr;
        tx_q <= rd_data;
      end
    end
  end

  // register storage and hand-off of each write
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= REG_RESET;
      regs_q[0] <= CONFIG_RESET;
      evt_q <= '0;
      wr_tog_q <= 1'b0;
    end
    else if (!cs_n && wr_hit)
    begin
      if (soft_rst)
      begin
        for (int i = 0; i < NUM_REGS; i++)
          regs_q[i] <= REG_RESET;
        regs_q[0] <= CONFIG_RESET;
      end
      else
        regs_q[addr_q[3:0]] <= byte_next;
      evt_q <= '{addr: addr_q, data: byte_next};
      wr_tog_q <= ~wr_tog_q;
    end
  end

  // read bit select for the current bit position
  wire logic [2:0] tx_idx = cfg_lsb ? cnt_q[2:0] : 3'(3'h7 - cnt_q[2:0]);

  // output bits change on falling edges, and clear when cs_n rises or on reset
  always_ff @(negedge sclk or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n || cs_n)
    begin
      out_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      out_q <= tx_q[tx_idx];
      drive_q <= (phase_q == PH_DATA) && rw_q;
    end
  end

  // pin steering between 3-wire and 4-wire use
  assign sdio_out = out_q;
  assign sdio_oe = drive_q && !cfg_four_wire;
  assign serial_out_line = out_q;
  assign serial_out_oe = drive_q && cfg_four_wire;

  // ---------------- system (sys_clk) domain ----------------
  logic tog_sync;
  logic tog_seen_q;
  logic [7:0] cfg_q [NUM_REGS];

  level_sync #(.WIDTH(1)) u_tog_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .async_in(wr_tog_q),
    .sync_out(tog_sync)
  );

  // event seen when the synchronised toggle flips
  wire logic wr_seen = tog_sync ^ tog_seen_q;
  wire logic sys_soft = (evt_q.addr == REG_CONFIG) && evt_q.data[CFG_SOFT_RESET_BIT];

  // status capture, toggle tracking
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stat_sys_q <= 8'h00;
      tog_seen_q <= 1'b0;
    end
    else
    begin
      stat_sys_q <= status_in;
      tog_seen_q <= tog_sync;
    end
  end

  // system copy of the register window, stable evt_q read after sync
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || (wr_seen && sys_soft))
    begin
      for (int i = 0; i < NUM_REGS; i++)
        cfg_q[i] <= REG_RESET;
      cfg_q[0] <= CONFIG_RESET;
    end
    else if (wr_seen)
      cfg_q[evt_q.addr[3:0]] <= evt_q.data;
  end

  // flatten the copy onto the configuration port
  generate
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_cfg
      assign cfg_out[g*8 +: 8] = cfg_q[g];
    end
  endgenerate

  assign low_bit_order_select = cfg_q[0][CFG_LSB_FIRST_BIT];

endmodule

// ### hdl/cfg_port_pkg.sv
/*
  constants, field positions and carrier types for the serial
  configuration port slave.
  assumes: included before both design modules.
*/
package cfg_port_pkg;

  // framing of one chip-select-low cycle
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 15;
  localparam logic [3:0] INSTR_LAST_CNT = 4'hF;
  localparam logic [3:0] BYTE_LAST_CNT = 4'h7;
  localparam int INSTR_RW_BIT = 15;

  // serial clock limit assumed of the master, in MHz; the bench host model runs sclk at a 48 ns period
  localparam int SCLK_MAX_MHZ = 10;

  // implemented register window
  localparam int NUM_REGS = 16;
  localparam logic [14:0] REG_CONFIG = 15'h0000;
  localparam logic [14:0] REG_STATUS = 15'h0001;
  localparam logic [14:0] REG_CHIP_TYPE = 15'h0003;
  localparam logic [14:0] REG_PROD_ID_LO = 15'h0004;
  localparam logic [14:0] REG_PROD_ID_HI = 15'h0005;
  localparam logic [14:0] REG_GRADE_REV = 15'h0006;

  // fields of the config register, upper nibble carries the decode
  localparam int CFG_SOFT_RESET_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_ADDR_INC_BIT = 5;
  localparam int CFG_FOUR_WIRE_BIT = 4;

  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // identity bytes, values arbitrary
  localparam logic [7:0] CHIP_TYPE_CODE = 8'h5A;
  localparam logic [7:0] PROD_ID_LO_CODE = 8'h12;
  localparam logic [7:0] PROD_ID_HI_CODE = 8'h34;
  localparam logic [7:0] GRADE_REV_CODE = 8'h11;

  // sequencing phase of the link-side shifter
  typedef enum logic [0:0] {
    PH_INSTR = 1'b0,
    PH_DATA = 1'b1
  } phase_t;

  // one register write handed from link side to system side
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } wr_evt_t;

endpackage

// ### hdl/level_sync.sv
/*
  two flip-flop synchroniser for levels, one stage pair per bit.
  assumes: each bit changes slowly against clk or is qualified elsewhere.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and synchronous reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // level from the other domain
  input wire logic [WIDTH-1:0] async_in,
  // synchronised level
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule

// ### tb/config_serial_port_slave_monitor.sv
/* checker for the config port slave.
   assumes: bound to the top; sclk idle outside frames. */
`timescale 1ns/1ps
module config_serial_port_slave_monitor
  import cfg_port_pkg::*;
(
  // clocks and link
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  // read path and system copy
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic [NUM_REGS*8-1:0] cfg_out,
  input wire logic low_bit_order_select
);
  logic [4:0] cnt_q;
  logic bit_q;
  logic [3:0] idle_q;
  wire oe = sdio_oe | serial_out_oe;
  // rises in this frame, read bit seen at each rise
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
  end
  always_ff @(posedge sclk) bit_q <= serial_out_line;
  // system cycles since deselect
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !cs_n) idle_q <= 4'h0;
    else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
  end
  a_idle_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_n |-> !oe) else $error("driven while idle");
  a_instr_quiet: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
    cnt_q < 5'h10 |-> !oe) else $error("driven in instruction");
  a_drive_at_16: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
    $rose(oe) |-> cnt_q == 5'h10) else $error("drive start wrong");
  a_drive_holds: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
    cnt_q > 5'h10 && $past(oe) |-> oe) else $error("drive dropped");
  // exactly one of the two read lines is driven in a read data phase
  a_one_line: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
    oe |-> sdio_oe != serial_out_oe) else $error("both read lines driven");
  a_bit_steady: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
    oe && cnt_q > 5'h10 |-> serial_out_line == bit_q) else $error("bit moved");
  a_cfg_settles: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(cfg_out) |-> idle_q < 4'hC) else $error("late update");
  // order bit of the system copy only moves right around a frame
  a_order_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(low_bit_order_select) |-> idle_q < 4'h6) else $error("order moved late");
endmodule

bind config_serial_port_slave config_serial_port_slave_monitor u_monitor (.*);

// ### tb/spi_host_model.sv
/* serial master model for the config port.
   assumes: read line resolved by the bench into miso. */
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // idle link: clock still, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // one frame, stopped after nclk clocks
  task automatic xfer(input logic lsb, input logic [15:0] ins, input int nclk,
    input logic [31:0] wd, output logic [31:0] rd);
    int b;
    rd = '0;
    #5 cs_n = 1'b0;
    for (int k = 0; k < nclk; k++)
    begin
      b = k < 16 ? (lsb ? k : 15 - k) : 8 * ((k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
      mosi = k < 16 ? ins[b] : wd[b];
      #24 sclk = 1'b1;
      if (k > 15) rd[b] = miso;
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    mosi = ~mosi;
    #48;
  endtask
endmodule

// ### tb/config_serial_port_slave_bench.sv
/* bench for the config port slave.
   assumes: host model drives the link; shared line resolved here. */
`timescale 1ns/1ps
module config_serial_port_slave_bench;
  import cfg_port_pkg::*;
  logic sys_clk, rst_n, lsb, inc;
  logic [7:0] status_in;
  logic [7:0] regs [NUM_REGS];
  logic [31:0] rd;
  int mismatches, samples_checked, seed, i, j;
  wire sclk, cs_n, mosi, so_line, so_oe, io, io_oe, lbo;
  wire [NUM_REGS*8-1:0] cfg;
  // shared line and read path
  wire sdio_in = io_oe ? io : mosi;
  // undriven read line shows the inverse, so a missing enable is caught
  wire miso = so_oe ? so_line : (io_oe ? io : ~io);
  config_serial_port_slave u_config_serial_port_slave (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(io), .sdio_oe(io_oe),
    .serial_out_line(so_line), .serial_out_oe(so_oe), .status_in(status_in),
    .cfg_out(cfg), .low_bit_order_select(lbo));
  spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected read value and writability of an address
  function automatic logic [7:0] peek(input logic [14:0] a);
    case (a)
      REG_STATUS: return status_in;
      REG_CHIP_TYPE: return CHIP_TYPE_CODE;
      REG_PROD_ID_LO: return PROD_ID_LO_CODE;
      REG_PROD_ID_HI: return PROD_ID_HI_CODE;
      REG_GRADE_REV: return GRADE_REV_CODE;
      default: return a < NUM_REGS ? regs[a[3:0]] : UNMAPPED_READ;
    endcase
  endfunction
  function automatic bit wok(input logic [14:0] a);
    return a < NUM_REGS && a != REG_STATUS && (a < REG_CHIP_TYPE || a > REG_GRADE_REV);
  endfunction
  // one frame; expectations per byte
  task automatic frame(input logic [15:0] ins, input int n, input int nclk,
    input logic [31:0] d);
    logic [14:0] p;
    p = ins[14:0];
    u_spi_host_model.xfer(lsb, ins, nclk, d, rd);
    for (int k = 0; k < n; k++)
    begin
      if (ins[15]) check("read", rd[8*k+:8], peek(p));
      else if (wok(p) && nclk >= 24 + 8 * k) regs[p[3:0]] = d[8*k+:8];
      p = inc ? p + 15'h0001 : p - 15'h0001;
    end
  endtask
  task automatic cmp();
    repeat (8) @(posedge sys_clk);
    for (int g = 0; g < NUM_REGS; g++)
      check("cfg", cfg[g*8+:8], regs[g]);
    check("order", lbo, regs[0][CFG_LSB_FIRST_BIT]);
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
  // reset, then every mode with random bursts
  initial
  begin
    seed = 32'hB1DC;
    rst_n = 1'b1;
    {lsb, inc, status_in} = '0;
    for (i = 0; i < NUM_REGS; i++) regs[i] = REG_RESET;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp();
    frame(16'h8006, 4, 48, 0);
    for (i = 0; i < 8; i++)
    begin
      frame(16'h0000, 1, 24, 32'({i[2:0], 4'h0}));
      {lsb, inc} = i[2:1];
      @(posedge sys_clk);
      status_in <= 8'($random(seed));
      j = inc ? 7 + $unsigned($random(seed)) % 6 : 15 - $unsigned($random(seed)) % 6;
      frame(16'(j), 4, 48, $random(seed));
      cmp();
      frame(16'h8000, 3, 40, 0);
      frame(16'h8000 | 16'(j), 4, 48, 0);
    end
    frame(16'h0004, 2, 32, $random(seed));
    frame(16'h8004, 2, 32, 0);
    frame(16'h0009, 2, 28, $random(seed));
    cmp();
    frame(16'h0000, 1, 24, 8'h80);
    {lsb, inc} = '0;
    for (i = 0; i < NUM_REGS; i++) regs[i] = REG_RESET;
    cmp();
    frame(16'h8009, 1, 24, 0);
    report_and_stop();
  end
endmodule
